// ==== display_latch_model.sv ====
// behavioural model of two latched bcd display units sharing four strobes
// assumes the bench hands it the polarity code that the block was given
`default_nettype none
module display_latch_model (
    // clock
    input wire logic clk_sys,
    // display pins driven by the block
    input wire logic [3:0] data_a,
    input wire logic [3:0] data_b,
    input wire logic [3:0] strobe,
    input wire logic [2:0] code,
    // digits held by each unit, units digit in the low nibble
    output logic [15:0] shown_a,
    output logic [15:0] shown_b
);
    timeunit 1ns;
    timeprecision 1ps;

    // units power up blank
    initial begin
        shown_a = 16'h0000;
        shown_b = 16'h0000;
    end

    // a digit follows its data only while its strobe sits at the active level
    always @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if ((strobe[i] ^ code[0]) === 1'b1) begin
                shown_a[i*4 +: 4] <= data_a ^ {4{code[1]}};
                shown_b[i*4 +: 4] <= data_b ^ {4{code[1]}};
            end
        end
    end
endmodule
`default_nettype wire

// ==== display_pkg.sv ====
// constants, register map and types shared by the display multiplexer
// assumes a 50 MHz system clock and an ahb-lite bus of 32-bit words
`default_nettype none
package display_pkg;
    // register byte offsets, decoded from the low address byte
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VAL0 = 8'h04;
    localparam logic [7:0] ADDR_VAL1 = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    // control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CODE_LSB = 4;
    localparam int CODE_W = 3;
    localparam int CODE_TWO_BIT = 2;
    localparam int CODE_DINV_BIT = 1;
    localparam int CODE_SINV_BIT = 0;
    // status fields
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_RUN_BIT = 1;
    localparam int STAT_DIGIT_LSB = 8;
    localparam int STAT_PHASE_LSB = 12;
    // data widths
    localparam int VALUE_W = 16;
    localparam int WORD_W = 32;
    localparam int BUF_ENTRIES = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;
    // sequencing: three ticks per digit, four digits per pass
    localparam logic [1:0] PHASE_SETUP = 2'h0;
    localparam logic [1:0] PHASE_LATCH = 2'h1;
    localparam logic [1:0] PHASE_HOLD = 2'h2;
    localparam logic [1:0] LAST_DIGIT = 2'h3;
    localparam logic [3:0] STEPS_PER_PASS = 4'hc;
    // ahb-lite
    localparam int HTRANS_ACT_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN} seq_state_e;
endpackage
`default_nettype wire

// ==== latched_display_multiplexer.sv ====
// time-multiplexed driver for one or two latched bcd display sets
// assumes scan_tick is a one-cycle pulse at least 10 ms apart
//
// Overview of operation
// - convert value 0 to bcd, show its four digits one after another
// - pulse one strobe per digit so each display digit latches its data
// - two-set mode also converts value 1 onto the second data group
// - the same four strobes latch both sets at once
// - codes 0-3 select one set, codes 4-7 select two sets
// - code bit 1 inverts data outputs, code bit 0 inverts strobes
// - data output level maps bcd ones according to data polarity
// - strobe active level follows strobe polarity
// - raise the completion flag after each full four-digit pass
// - one full pass takes exactly twelve sequencing ticks
// - repeat while enabled; disable aborts; re-enable starts at step one
// - one-set uses one value, two-set uses two; spare outputs reserved
// - set one comes from the first value word, set two from the next
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`default_nettype none
module latched_display_multiplexer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // sequencing tick
    input wire logic scan_tick,
    // display pins
    output logic [3:0] data_a,
    output logic [3:0] data_b,
    output logic [3:0] strobe,
    output logic pass_complete_flag
);
    typedef struct packed {
        display_pkg::seq_state_e seq;
        logic [1:0] digit;
        logic [1:0] phase;
        logic [31:0] bcd;
        logic [3:0] out_a;
        logic [3:0] out_b;
        logic [3:0] out_stb;
        logic dinv;
        logic sinv;
        logic done_pulse;
        logic done_sticky;
        logic enable;
        logic [2:0] code;
        logic [15:0] val0;
        logic [15:0] val1;
        logic ahb_act;
        logic ahb_wr;
        logic [7:0] ahb_addr;
        logic [31:0] rdata;
        logic [3:0] chk_ticks;
    } disp_s;

    disp_s st_reg;
    disp_s st_next;
    logic conv_valid;
    logic conv_ready;
    logic [31:0] conv_bcd;
    logic buf_valid;
    logic buf_pop;
    logic [31:0] buf_data;
    logic exec;
    logic at_start;
    logic [31:0] word;

    // pick the bcd digit of one set out of a converted word
    function automatic logic [3:0] nib(input logic [31:0] w, input logic set_b,
                                       input logic [1:0] d);
        return w[{set_b, d, 2'b00} +: 4];
    endfunction

    // strobe pattern of one digit before polarity
    function automatic logic [3:0] onehot(input logic [1:0] d);
        return 4'h1 << d;
    endfunction

    // conversion runs far ahead of the ticks; the buffer absorbs it
    value_converter u_conv (
        .clk_sys(clk_sys),
        .rst(rst),
        .value_a(st_reg.val0),
        .value_b(st_reg.val1),
        .out_valid(conv_valid),
        .out_ready(conv_ready),
        .out_bcd(conv_bcd)
    );

    // drained once per pass, so it fills and stalls the converter
    pair_buffer u_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(conv_valid),
        .in_ready(conv_ready),
        .in_data(conv_bcd),
        .out_valid(buf_valid),
        .out_ready(buf_pop),
        .out_data(buf_data)
    );

    assign at_start = st_reg.digit == 2'h0 && st_reg.phase == display_pkg::PHASE_SETUP;

    // bus slave, then sequencer; hardware set of the flag comes last
    always_comb begin
        st_next = st_reg;
        st_next.done_pulse = 1'b0;
        buf_pop = 1'b0;
        exec = 1'b0;
        word = st_reg.bcd;
        // address phase: read data is captured here
        st_next.ahb_act = hsel && hready && htrans[display_pkg::HTRANS_ACT_BIT];
        if (st_next.ahb_act) begin
            st_next.ahb_wr = hwrite;
            st_next.ahb_addr = haddr[display_pkg::ADDR_W-1:0];
            st_next.rdata = '0;
            if (!hwrite) begin
                case (haddr[display_pkg::ADDR_W-1:0])
                    display_pkg::ADDR_CTRL: begin
                        st_next.rdata[display_pkg::CTRL_EN_BIT] = st_reg.enable;
                        st_next.rdata[display_pkg::CTRL_CODE_LSB +: display_pkg::CODE_W] =
                            st_reg.code;
                    end
                    display_pkg::ADDR_VAL0: begin
                        st_next.rdata[display_pkg::VALUE_W-1:0] = st_reg.val0;
                    end
                    display_pkg::ADDR_VAL1: begin
                        st_next.rdata[display_pkg::VALUE_W-1:0] = st_reg.val1;
                    end
                    display_pkg::ADDR_STATUS: begin
                        st_next.rdata[display_pkg::STAT_DONE_BIT] = st_reg.done_sticky;
                        st_next.rdata[display_pkg::STAT_RUN_BIT] =
                            st_reg.seq == display_pkg::SEQ_RUN;
                        st_next.rdata[display_pkg::STAT_DIGIT_LSB +: 2] = st_reg.digit;
                        st_next.rdata[display_pkg::STAT_PHASE_LSB +: 2] = st_reg.phase;
                    end
                    default: begin
                        st_next.rdata = '0;
                    end
                endcase
            end
        end
        // data phase: writes land here, unmapped ones are dropped
        if (st_reg.ahb_act && st_reg.ahb_wr) begin
            case (st_reg.ahb_addr)
                display_pkg::ADDR_CTRL: begin
                    st_next.enable = hwdata[display_pkg::CTRL_EN_BIT];
                    st_next.code = hwdata[display_pkg::CTRL_CODE_LSB +: display_pkg::CODE_W];
                end
                display_pkg::ADDR_VAL0: begin
                    st_next.val0 = hwdata[display_pkg::VALUE_W-1:0];
                end
                display_pkg::ADDR_VAL1: begin
                    st_next.val1 = hwdata[display_pkg::VALUE_W-1:0];
                end
                display_pkg::ADDR_STATUS: begin
                    if (hwdata[display_pkg::STAT_DONE_BIT]) begin
                        st_next.done_sticky = 1'b0;
                    end
                end
                default: begin
                    st_next.done_sticky = st_next.done_sticky;
                end
            endcase
        end
        // display sequencer
        case (st_reg.seq)
            display_pkg::SEQ_IDLE: begin
                // idle: strobes inactive, data at logic zero, next pass from step one
                st_next.digit = 2'h0;
                st_next.phase = display_pkg::PHASE_SETUP;
                st_next.dinv = st_reg.code[display_pkg::CODE_DINV_BIT];
                st_next.sinv = st_reg.code[display_pkg::CODE_SINV_BIT];
                st_next.out_a = {4{st_next.dinv}};
                st_next.out_b = {4{st_next.dinv}};
                st_next.out_stb = {4{st_next.sinv}};
                st_next.chk_ticks = 4'h0;
                if (st_reg.enable) begin
                    st_next.seq = display_pkg::SEQ_RUN;
                end
            end
            display_pkg::SEQ_RUN: begin
                if (!st_reg.enable) begin
                    st_next.seq = display_pkg::SEQ_IDLE;
                end else if (scan_tick && (!at_start || buf_valid)) begin
                    // a pass only starts once a fresh bcd word is ready
                    exec = 1'b1;
                    st_next.chk_ticks = st_reg.chk_ticks + 4'h1;
                    if (at_start) begin
                        buf_pop = 1'b1;
                        word = buf_data;
                        st_next.bcd = buf_data;
                        st_next.chk_ticks = 4'h1;
                    end
                    st_next.sinv = st_reg.code[display_pkg::CODE_SINV_BIT];
                    case (st_reg.phase)
                        display_pkg::PHASE_SETUP: begin
                            // data changes only while strobes are inactive
                            st_next.dinv = st_reg.code[display_pkg::CODE_DINV_BIT];
                            st_next.out_a = nib(word, 1'b0, st_reg.digit) ^
                                {4{st_next.dinv}};
                            st_next.out_b = {4{st_next.dinv}};
                            if (st_reg.code[display_pkg::CODE_TWO_BIT]) begin
                                st_next.out_b = nib(word, 1'b1, st_reg.digit) ^
                                    {4{st_next.dinv}};
                            end
                            st_next.out_stb = {4{st_next.sinv}};
                            st_next.phase = display_pkg::PHASE_LATCH;
                        end
                        display_pkg::PHASE_LATCH: begin
                            // one strobe serves both sets
                            st_next.out_stb = onehot(st_reg.digit) ^
                                {4{st_next.sinv}};
                            st_next.phase = display_pkg::PHASE_HOLD;
                        end
                        default: begin
                            st_next.out_stb = {4{st_next.sinv}};
                            st_next.phase = display_pkg::PHASE_SETUP;
                            st_next.digit = st_reg.digit + 2'h1;
                            if (st_reg.digit == display_pkg::LAST_DIGIT) begin
                                st_next.done_pulse = 1'b1;
                                st_next.done_sticky = 1'b1;
                            end
                        end
                    endcase
                end
            end
            default: begin
                st_next.seq = display_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = display_pkg::HRESP_OKAY;
    assign hrdata = st_reg.rdata;
    assign data_a = st_reg.out_a;
    assign data_b = st_reg.out_b;
    assign strobe = st_reg.out_stb;
    assign pass_complete_flag = st_reg.done_pulse;

    // logical view of the pins with the polarity in force removed
    logic [3:0] a_logic;
    logic [3:0] b_logic;
    logic [3:0] stb_logic;
    assign a_logic = st_reg.out_a ^ {4{st_reg.dinv}};
    assign b_logic = st_reg.out_b ^ {4{st_reg.dinv}};
    assign stb_logic = st_reg.out_stb ^ {4{st_reg.sinv}};

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_data_digit;
        exec && st_reg.phase == display_pkg::PHASE_SETUP |=>
            a_logic == nib($past(word), 1'b0, $past(st_reg.digit));
    endproperty
    a_data_digit: assert property (p_data_digit) else $error("set a digit wrong");

    property p_strobe_latch;
        exec && st_reg.phase == display_pkg::PHASE_LATCH |=>
            stb_logic == onehot($past(st_reg.digit));
    endproperty
    a_strobe_latch: assert property (p_strobe_latch) else $error("wrong strobe");

    property p_set_b;
        exec && st_reg.phase == display_pkg::PHASE_SETUP &&
            st_reg.code[display_pkg::CODE_TWO_BIT] |=>
            b_logic == nib($past(word), 1'b1, $past(st_reg.digit));
    endproperty
    a_set_b: assert property (p_set_b) else $error("set b digit wrong");

    property p_strobe_shared;
        $onehot0(stb_logic);
    endproperty
    a_strobe_shared: assert property (p_strobe_shared) else $error("two strobes");

    property p_one_set;
        exec && st_reg.phase == display_pkg::PHASE_SETUP &&
            !st_reg.code[display_pkg::CODE_TWO_BIT] |=> b_logic == 4'h0;
    endproperty
    a_one_set: assert property (p_one_set) else $error("set b not idle");

    property p_idle_levels;
        // idle polarity trails a code write by one cycle
        st_reg.seq == display_pkg::SEQ_IDLE && $past(st_reg.seq) == display_pkg::SEQ_IDLE
            |-> a_logic == 4'h0 &&
            st_reg.dinv == $past(st_reg.code[display_pkg::CODE_DINV_BIT]);
    endproperty
    a_idle_levels: assert property (p_idle_levels) else $error("idle data level");

    property p_strobe_quiet;
        exec && st_reg.phase != display_pkg::PHASE_LATCH |=> stb_logic == 4'h0;
    endproperty
    a_strobe_quiet: assert property (p_strobe_quiet) else $error("strobe active");

    property p_done;
        pass_complete_flag |-> st_reg.done_sticky ##1 !pass_complete_flag;
    endproperty
    a_done: assert property (p_done) else $error("completion flag wrong");

    property p_pass_len;
        pass_complete_flag |-> st_reg.chk_ticks == display_pkg::STEPS_PER_PASS;
    endproperty
    a_pass_len: assert property (p_pass_len) else $error("pass length wrong");

    property p_abort;
        st_reg.seq == display_pkg::SEQ_RUN && !st_reg.enable |=>
            st_reg.seq == display_pkg::SEQ_IDLE ##1
            (stb_logic == 4'h0 && st_reg.digit == 2'h0 && !pass_complete_flag);
    endproperty
    a_abort: assert property (p_abort) else $error("abort not clean");

    property p_hold;
        exec && st_reg.phase != display_pkg::PHASE_SETUP |=>
            $stable(st_reg.out_a) && $stable(st_reg.out_b);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved under strobe");

    // main scenarios
    c_two_set_pass: cover property (pass_complete_flag && st_reg.code[display_pkg::CODE_TWO_BIT]);
    c_one_set_pass: cover property (pass_complete_flag && !st_reg.code[display_pkg::CODE_TWO_BIT]);
    c_abort_mid: cover property (st_reg.seq == display_pkg::SEQ_RUN && !st_reg.enable &&
                                 st_reg.digit != 2'h0);
    c_buf_full: cover property (!conv_ready);
endmodule
`default_nettype wire

// ==== muxed_bcd_latch_display_driver_test.sv ====
// self-checking bench for the latched display multiplexer
// assumes a single 50 MHz clock; tick spacing is shortened, the block never measures it
`default_nettype none
module muxed_bcd_latch_display_driver_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic scan_tick = 1'b0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [3:0] data_a;
    logic [3:0] data_b;
    logic [3:0] strobe;
    logic pass_complete_flag;
    logic [15:0] shown_a;
    logic [15:0] shown_b;
    logic [2:0] code = 3'h0;
    int cur_v0 = 0;
    int cur_v1 = 0;
    int flag_cnt = 0;
    int num_errors = 0;
    int check_count = 0;

    latched_display_multiplexer u_dut (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scan_tick(scan_tick),
        .data_a(data_a), .data_b(data_b), .strobe(strobe),
        .pass_complete_flag(pass_complete_flag)
    );
    display_latch_model u_disp (
        .clk_sys(clk_sys), .data_a(data_a), .data_b(data_b), .strobe(strobe),
        .code(code), .shown_a(shown_a), .shown_b(shown_b)
    );

    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    // count completion pulses, one per cycle high
    always @(posedge clk_sys) begin
        if (pass_complete_flag === 1'b1) flag_cnt <= flag_cnt + 1;
    end

    task automatic print_verdict;
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [3:0] dig(input int v, input int i);
        return 4'((v / (10 ** i)) % 10);
    endfunction

    function automatic logic [15:0] bcd4(input int v);
        return {dig(v, 3), dig(v, 2), dig(v, 1), dig(v, 0)};
    endfunction

    // one ahb-lite single transfer; entered right after a rising edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        r = hrdata;
        chk(32'(hresp), 32'h0, "hresp");
    endtask

    // idle cycle after a write keeps a following read off the stale value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
        @(posedge clk_sys);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                          input string msg);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk(r & m, e, msg);
    endtask

    task automatic enable(input logic [2:0] c, input logic en);
        wr(display_pkg::ADDR_CTRL, (32'(c) << display_pkg::CTRL_CODE_LSB) | 32'(en));
        repeat (10) @(posedge clk_sys);
    endtask

    // one sequencing tick, then the pins are compared once settled
    task automatic tick(input int s, input bit full);
        logic [3:0] exp_s;
        exp_s = (s % 3 == 1) ? 4'(4'h1 << (s / 3)) : 4'h0;
        // fixed tick spacing, scaled down since the block never measures the period
        scan_tick <= 1'b1;
        @(posedge clk_sys);
        scan_tick <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'(strobe), 32'(exp_s ^ {4{code[0]}}), "strobe");
        if (full) begin
            chk(32'(data_a), 32'(dig(cur_v0, s / 3) ^ {4{code[1]}}), "data_a");
            chk(32'(data_b), 32'((code[2] ? dig(cur_v1, s / 3) : 4'h0) ^ {4{code[1]}}),
                "data_b");
        end
        @(posedge clk_sys);
    endtask

    // four full passes; two buffered words and the converter's held one may be stale
    task automatic run_code(input logic [2:0] c);
        int base;
        cur_v0 = (c == 3'h0) ? 0 : (c == 3'h7) ? 9999 : $urandom_range(9999);
        cur_v1 = (c == 3'h7) ? 0 : (c == 3'h4) ? 9999 : $urandom_range(9999);
        wr(display_pkg::ADDR_VAL0, 32'(cur_v0));
        wr(display_pkg::ADDR_VAL1, 32'(cur_v1));
        code = c;
        enable(c, 1'b1);
        for (int p = 0; p < 4; p++) begin
            base = flag_cnt;
            for (int s = 0; s < 12; s++) begin
                tick(s, p == 3);
                if (s == 10) chk(32'(flag_cnt), 32'(base), "early flag");
            end
            @(negedge clk_sys);
            chk(32'(flag_cnt), 32'(base + 1), "pass flag");
            @(posedge clk_sys);
        end
        chk(32'(shown_a), 32'(bcd4(cur_v0)), "set one");
        chk(32'(shown_b), 32'(c[2] ? bcd4(cur_v1) : 16'h0), "set two");
        enable(c, 1'b0);
    endtask

    // main sequence
    initial begin
        int base;
        void'($urandom(32'h4e13ddfe));
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        chk(32'({strobe, data_a, data_b}), 32'h0, "reset pins");
        @(posedge clk_sys);
        rd_chk(display_pkg::ADDR_CTRL, 32'hffffffff, 32'h0, "ctrl reset");
        rd_chk(display_pkg::ADDR_STATUS, 32'hffffffff, 32'h0, "status reset");
        wr(8'h10, 32'hffffffff);
        rd_chk(8'h10, 32'hffffffff, 32'h0, "unmapped");
        for (int c = 0; c < 8; c++) run_code(3'(c));
        // abort mid pass, ignored ticks, then restart from the first step
        code = 3'h5;
        enable(code, 1'b1);
        for (int s = 0; s < 5; s++) tick(s, 1'b0);
        enable(code, 1'b0);
        scan_tick <= 1'b1;
        @(posedge clk_sys);
        scan_tick <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'({strobe, data_a}), 32'hf0, "idle pins");
        @(posedge clk_sys);
        base = flag_cnt;
        enable(code, 1'b1);
        for (int s = 0; s < 12; s++) tick(s, 1'b1);
        @(negedge clk_sys);
        chk(32'(flag_cnt), 32'(base + 1), "restart pass");
        @(posedge clk_sys);
        rd_chk(display_pkg::ADDR_STATUS, 32'h1, 32'h1, "done set");
        wr(display_pkg::ADDR_STATUS, 32'h1);
        rd_chk(display_pkg::ADDR_STATUS, 32'h1, 32'h0, "done clear");
        print_verdict;
    end

    // watchdog, well beyond the under two thousand cycles the tests take
    initial begin
        #200000;
        num_errors++;
        print_verdict;
    end
endmodule
`default_nettype wire

// ==== pair_buffer.sv ====
// two-entry word buffer with valid/ready on both sides
// assumes the drain side may stall for any number of cycles
`default_nettype none
module pair_buffer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [31:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [31:0] out_data
);
    typedef struct packed {
        logic [display_pkg::BUF_ENTRIES-1:0][31:0] mem;
        logic [1:0] count;
        logic wr_ptr;
        logic rd_ptr;
    } buf_s;

    buf_s st_reg;
    buf_s st_next;
    logic push;
    logic pop;

    // full and empty come straight from the count
    assign in_ready = st_reg.count != display_pkg::BUF_FULL;
    assign out_valid = st_reg.count != 2'h0;
    assign out_data = st_reg.mem[st_reg.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr_ptr] = in_data;
            st_next.wr_ptr = !st_reg.wr_ptr;
        end
        if (pop) begin
            st_next.rd_ptr = !st_reg.rd_ptr;
        end
        case ({push, pop})
            2'b10: st_next.count = st_reg.count + 2'h1;
            2'b01: st_next.count = st_reg.count - 2'h1;
            default: st_next.count = st_reg.count;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// ==== value_converter.sv ====
// binary to bcd stage for both display sets, with a valid/ready output
// assumes input values stay within 0 to 9999; larger values wrap
`default_nettype none
module value_converter (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // binary values
    input wire logic [15:0] value_a,
    input wire logic [15:0] value_b,
    // bcd word out, set b in the upper half
    output logic out_valid,
    input wire logic out_ready,
    output logic [31:0] out_bcd
);
    typedef struct packed {
        logic valid;
        logic [31:0] bcd;
    } conv_s;

    conv_s st_reg;
    conv_s st_next;

    // shift-and-add-three, one pass per input bit
    function automatic logic [15:0] to_bcd(input logic [15:0] bin);
        logic [19:0] acc;
        acc = '0;
        for (int i = 15; i >= 0; i--) begin
            for (int d = 0; d < 5; d++) begin
                if (acc[d*4 +: 4] > 4'h4) begin
                    acc[d*4 +: 4] = acc[d*4 +: 4] + 4'h3;
                end
            end
            acc = {acc[18:0], bin[i]};
        end
        return acc[15:0];
    endfunction

    // refresh the snapshot whenever the buffer takes the last one
    always_comb begin
        st_next = st_reg;
        if (!st_reg.valid || out_ready) begin
            st_next.valid = 1'b1;
            st_next.bcd = {to_bcd(value_b), to_bcd(value_a)};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out_valid = st_reg.valid;
    assign out_bcd = st_reg.bcd;
endmodule
`default_nettype wire
